// file: rtl/tfoc_pkg.sv
package tfoc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FRAMING_SELECT = 8'h00;
  localparam logic [7:0] ADDR_RX_SIG_ARRAY   = 8'h04;
  localparam logic [7:0] ADDR_STATUS         = 8'h08;

  localparam logic [7:0] FRAMING_SELECT_RST  = 8'h00;

  // ---------------------------------------------------------------
  // framing_select field positions
  // ---------------------------------------------------------------
  localparam int BIT_SF_SIG_UPDATE = 7;
  localparam int BIT_FORCE_CRC     = 6;
  localparam int BIT_JAPAN_VARIANT = 5;
  localparam int BIT_SINGLE_CAND   = 4;
  localparam int FMT_MSB           = 2;

  // ---------------------------------------------------------------
  // framing formats
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TFOC_FMT_ESF = 2'h0,
    TFOC_FMT_SF  = 2'h1,
    TFOC_FMT_N   = 2'h3,
    TFOC_FMT_SLC = 2'h2
  } tfoc_fmt_t;

  localparam logic [2:0] FMT_CODE_SF  = 3'h5;
  localparam logic [2:0] FMT_CODE_N   = 3'h6;
  localparam logic [2:0] FMT_CODE_SLC = 3'h4;

  // ---------------------------------------------------------------
  // superframe lengths in frames
  // ---------------------------------------------------------------
  localparam logic [4:0] SF_FRAMES  = 5'h0C;
  localparam logic [4:0] ESF_FRAMES = 5'h18;

  // ---------------------------------------------------------------
  // crc and yellow alarm patterns
  // ---------------------------------------------------------------
  localparam logic [5:0]  CRC_ERR_MASK    = 6'h01;
  localparam logic [15:0] YEL_ESF_T1_WORD = 16'hFF00;
  localparam logic [15:0] YEL_ESF_J1_WORD = 16'hFFFF;
  localparam logic [15:0] YEL_IDLE_WORD   = 16'h0000;

endpackage : tfoc_pkg

// file: rtl/tfoc_sf_counter.sv
`timescale 1ns/10ps

module tfoc_sf_counter (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // frame timing
  input  wire logic frame_i,
  input  wire logic esf_i,
  // superframe boundary
  output logic      sf_boundary_o
);

  logic [4:0] cnt_q;
  logic [4:0] len;

  assign len = esf_i ? tfoc_pkg::ESF_FRAMES : tfoc_pkg::SF_FRAMES;

  // ---------------------------------------------------------------
  // frame counter, wraps on the active superframe length
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cnt_q <= 5'h00;
    end else if (frame_i) begin
      if (cnt_q >= len - 5'h01) begin
        cnt_q <= 5'h00;
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sf_boundary_o <= 1'b0;
    end else begin
      sf_boundary_o <= frame_i && (cnt_q >= len - 5'h01);
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  chk_sf_count_wrap: assert property (frame_i && cnt_q == len - 5'h01 |=> cnt_q == 5'h00 && sf_boundary_o)
    else $error("frame counter missed superframe wrap");
  chk_boundary_on_wrap: assert property (sf_boundary_o |-> cnt_q == 5'h00)
    else $error("boundary without counter wrap");

endmodule : tfoc_sf_counter

// file: rtl/tfoc_top.sv
`timescale 1ns/10ps

module tfoc_top #(
  parameter int SIG_W  = 4,
  parameter int CAND_N = 8
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 reset_n_i,
  // register port
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  // frame timing
  input  wire logic                 rx_frame_i,
  input  wire logic                 tx_frame_i,
  // receive signaling
  input  wire logic [SIG_W-1:0]     rx_sig_i,
  input  wire logic                 rx_sig_valid_i,
  output logic      [SIG_W-1:0]     rx_signaling_out_o,
  // transmit signaling
  input  wire logic [SIG_W-1:0]     tx_sig_i,
  input  wire logic                 tx_sig_valid_i,
  output logic      [SIG_W-1:0]     tx_sig_o,
  // crc
  input  wire logic [5:0]           tx_crc_i,
  input  wire logic                 tx_crc_valid_i,
  output logic      [5:0]           tx_crc_o,
  input  wire logic                 crc_bit_i,
  input  wire logic                 extended_frame_alignment_bit_i,
  output logic                      crc_feed_o,
  // yellow alarm
  input  wire logic                 tx_yellow_req_i,
  output logic      [15:0]          yel_dl_word_o,
  output logic                      yel_sf_bit2_zero_o,
  output logic                      yel_sf_fs_one_o,
  input  wire logic [15:0]          rx_dl_word_i,
  input  wire logic                 rx_sf_bit2_zero_i,
  input  wire logic                 rx_sf_fs_one_i,
  output logic                      rx_yellow_o,
  // sync candidates
  input  wire logic [CAND_N-1:0]    cand_mask_i,
  input  wire logic                 window_end_i,
  output logic                      sync_ok_o,
  output logic [$clog2(CAND_N)-1:0] sync_pos_o,
  // format
  output logic      [1:0]           fmt_o,
  output logic                      japan_variant_select_o
);

  localparam int POS_W = $clog2(CAND_N);

  logic [7:0]       framing_select_q;
  logic [SIG_W-1:0] rx_pend_q;
  logic [SIG_W-1:0] tx_pend_q;
  logic             sf_upd;
  logic             force_crc;
  logic             j1;
  logic             single_cand;
  logic             esf;
  logic             sf_like;
  tfoc_pkg::tfoc_fmt_t fmt;
  logic             rx_bnd;
  logic             tx_bnd;
  logic [POS_W:0]   cand_cnt;
  logic [POS_W-1:0] cand_pos;
  logic             rx_yel;

  assign sf_upd      = framing_select_q[tfoc_pkg::BIT_SF_SIG_UPDATE];
  assign force_crc   = framing_select_q[tfoc_pkg::BIT_FORCE_CRC];
  assign j1          = framing_select_q[tfoc_pkg::BIT_JAPAN_VARIANT];
  assign single_cand = framing_select_q[tfoc_pkg::BIT_SINGLE_CAND];

  // ---------------------------------------------------------------
  // format decode; code 111 is unlisted and treated as sf
  // ---------------------------------------------------------------
  always_comb begin
    if (!framing_select_q[tfoc_pkg::FMT_MSB]) begin
      fmt = tfoc_pkg::TFOC_FMT_ESF;
    end else if (framing_select_q[2:0] == tfoc_pkg::FMT_CODE_N) begin
      fmt = tfoc_pkg::TFOC_FMT_N;
    end else if (framing_select_q[2:0] == tfoc_pkg::FMT_CODE_SLC) begin
      fmt = tfoc_pkg::TFOC_FMT_SLC;
    end else begin
      fmt = tfoc_pkg::TFOC_FMT_SF;
    end
  end

  assign esf     = (fmt == tfoc_pkg::TFOC_FMT_ESF);
  assign sf_like = !esf;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      framing_select_q <= tfoc_pkg::FRAMING_SELECT_RST;
    end else if (wr_i && addr_i == tfoc_pkg::ADDR_FRAMING_SELECT) begin
      framing_select_q <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        tfoc_pkg::ADDR_FRAMING_SELECT: rdata_o <= framing_select_q;
        tfoc_pkg::ADDR_RX_SIG_ARRAY:   rdata_o <= 8'(rx_signaling_out_o);
        tfoc_pkg::ADDR_STATUS:         rdata_o <= {5'h00, rx_yellow_o, sync_ok_o, j1};
        default:                       rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // superframe boundaries
  // ---------------------------------------------------------------
  tfoc_sf_counter u_rx_sf (
    .mclk_i        (mclk_i),
    .reset_n_i     (reset_n_i),
    .frame_i       (rx_frame_i),
    .esf_i         (esf),
    .sf_boundary_o (rx_bnd)
  );

  tfoc_sf_counter u_tx_sf (
    .mclk_i        (mclk_i),
    .reset_n_i     (reset_n_i),
    .frame_i       (tx_frame_i),
    .esf_i         (esf),
    .sf_boundary_o (tx_bnd)
  );

  // ---------------------------------------------------------------
  // receive signaling; new data on a boundary cycle goes straight out
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rx_pend_q <= '0;
    end else if (rx_sig_valid_i) begin
      rx_pend_q <= rx_sig_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rx_signaling_out_o <= '0;
    end else if (!sf_upd) begin
      if (rx_sig_valid_i) begin
        rx_signaling_out_o <= rx_sig_i;
      end
    end else if (rx_bnd) begin
      rx_signaling_out_o <= rx_sig_valid_i ? rx_sig_i : rx_pend_q;
    end
  end

  // ---------------------------------------------------------------
  // transmit signaling
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tx_pend_q <= '0;
    end else if (tx_sig_valid_i) begin
      tx_pend_q <= tx_sig_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tx_sig_o <= '0;
    end else if (!sf_upd) begin
      if (tx_sig_valid_i) begin
        tx_sig_o <= tx_sig_i;
      end
    end else if (tx_bnd) begin
      tx_sig_o <= tx_sig_valid_i ? tx_sig_i : tx_pend_q;
    end
  end

  // ---------------------------------------------------------------
  // crc insertion and crc6 input bit
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tx_crc_o <= 6'h00;
    end else if (tx_crc_valid_i) begin
      tx_crc_o <= force_crc ? (tx_crc_i ^ tfoc_pkg::CRC_ERR_MASK) : tx_crc_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      crc_feed_o <= 1'b0;
    end else begin
      crc_feed_o <= (extended_frame_alignment_bit_i && !j1) ? 1'b1 : crc_bit_i;
    end
  end

  // ---------------------------------------------------------------
  // yellow alarm
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      yel_dl_word_o      <= tfoc_pkg::YEL_IDLE_WORD;
      yel_sf_bit2_zero_o <= 1'b0;
      yel_sf_fs_one_o    <= 1'b0;
    end else begin
      yel_dl_word_o      <= (tx_yellow_req_i && esf)
                            ? (j1 ? tfoc_pkg::YEL_ESF_J1_WORD : tfoc_pkg::YEL_ESF_T1_WORD)
                            : tfoc_pkg::YEL_IDLE_WORD;
      yel_sf_bit2_zero_o <= tx_yellow_req_i && sf_like && !j1;
      yel_sf_fs_one_o    <= tx_yellow_req_i && sf_like && j1;
    end
  end

  always_comb begin
    if (esf) begin
      rx_yel = rx_dl_word_i == (j1 ? tfoc_pkg::YEL_ESF_J1_WORD : tfoc_pkg::YEL_ESF_T1_WORD);
    end else begin
      rx_yel = j1 ? rx_sf_fs_one_i : rx_sf_bit2_zero_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rx_yellow_o <= 1'b0;
    end else begin
      rx_yellow_o <= rx_yel;
    end
  end

  // ---------------------------------------------------------------
  // sync candidate selection; lowest winner is taken
  // ---------------------------------------------------------------
  always_comb begin
    cand_cnt = '0;
    cand_pos = '0;
    for (int i = CAND_N - 1; i >= 0; i--) begin
      if (cand_mask_i[i]) begin
        cand_cnt = cand_cnt + (POS_W+1)'(1);
        cand_pos = POS_W'(i);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sync_ok_o  <= 1'b0;
      sync_pos_o <= '0;
    end else if (window_end_i) begin
      sync_ok_o  <= single_cand ? (cand_cnt == (POS_W+1)'(1))
                                : (cand_cnt != '0);
      sync_pos_o <= cand_pos;
    end
  end

  // ---------------------------------------------------------------
  // format outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      fmt_o                  <= tfoc_pkg::TFOC_FMT_ESF;
      japan_variant_select_o <= 1'b0;
    end else begin
      fmt_o                  <= fmt;
      japan_variant_select_o <= j1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_rx_deferred;
    sf_upd && !rx_bnd && rx_sig_valid_i;
  endsequence

  chk_rx_sig_immediate: assert property (!sf_upd && rx_sig_valid_i |=> rx_signaling_out_o == $past(rx_sig_i))
    else $error("rx signaling not updated at once");
  chk_rx_sig_deferred: assert property (s_rx_deferred |=> $stable(rx_signaling_out_o))
    else $error("rx signaling changed off boundary");
  chk_tx_sig_hold: assert property (sf_upd && !tx_bnd |=> $stable(tx_sig_o))
    else $error("tx signaling changed off boundary");
  chk_crc_forced: assert property (tx_crc_valid_i && force_crc |=> tx_crc_o != $past(tx_crc_i))
    else $error("crc error not inserted");
  chk_crc_clean: assert property (tx_crc_valid_i && !force_crc |=> tx_crc_o == $past(tx_crc_i))
    else $error("crc corrupted while not forced");
  chk_fe_as_one: assert property (!j1 && extended_frame_alignment_bit_i |=> crc_feed_o)
    else $error("framing bit not forced to one in t1");
  chk_yellow_j1_esf: assert property (j1 && esf && tx_yellow_req_i |=> yel_dl_word_o == tfoc_pkg::YEL_ESF_J1_WORD)
    else $error("wrong j1 esf yellow pattern");
  chk_reset_t1: assert property ($rose(reset_n_i) |-> !japan_variant_select_o && !j1)
    else $error("not in t1 after reset");
  chk_single_sync: assert property (window_end_i && single_cand && cand_cnt > (POS_W+1)'(1) |=> !sync_ok_o)
    else $error("sync declared with several candidates");
  chk_any_sync: assert property (window_end_i && !single_cand && cand_cnt != '0 |=> sync_ok_o)
    else $error("sync refused with winners present");
  chk_esf_decode: assert property (!framing_select_q[2] |=> fmt_o == tfoc_pkg::TFOC_FMT_ESF)
    else $error("esf not decoded");

endmodule : tfoc_top

// file: tb/tfoc_line_model.sv
`timescale 1ns/10ps

module tfoc_line_model #(
  parameter int PERIOD = 4
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // control
  input  wire logic en_i,
  // frame timing
  output logic      rx_frame_o,
  output logic      tx_frame_o
);
  // ---------------------------------------------------------------
  // frame pulses, one cycle every PERIOD cycles while enabled
  // ---------------------------------------------------------------
  int cnt_q;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !en_i) begin
      cnt_q      <= 0;
      rx_frame_o <= 1'b0;
      tx_frame_o <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      rx_frame_o <= (cnt_q == PERIOD - 1);
      tx_frame_o <= (cnt_q == PERIOD - 1);
    end
  end
endmodule : tfoc_line_model

// file: tb/tfoc_top_bench.sv
`timescale 1ns/10ps

module tfoc_top_bench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] cand;
    logic       ok;
    logic [2:0] pos;
    logic [1:0] fmt;
  } tfoc_row_t;

  localparam tfoc_row_t ROWS [9] = '{
    '{8'h00, 8'h00, 1'b0, 3'h0, 2'h0}, '{8'h05, 8'h06, 1'b1, 3'h1, 2'h1},
    '{8'h15, 8'h06, 1'b0, 3'h0, 2'h1}, '{8'h16, 8'h20, 1'b1, 3'h5, 2'h3},
    '{8'h64, 8'h80, 1'b1, 3'h7, 2'h2}, '{8'h23, 8'hFF, 1'b1, 3'h0, 2'h0},
    '{8'h25, 8'h18, 1'b1, 3'h3, 2'h1}, '{8'h72, 8'h40, 1'b1, 3'h6, 2'h0},
    '{8'h07, 8'h01, 1'b1, 3'h0, 2'h1}};

  logic        mclk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, line_en = 1'b0;
  logic        rx_sig_valid_i = 1'b0, tx_sig_valid_i = 1'b0, tx_crc_valid_i = 1'b1, window_end_i = 1'b1;
  logic        crc_bit_i = 1'b0, extended_frame_alignment_bit_i = 1'b0, tx_yellow_req_i = 1'b0;
  logic        rx_sf_bit2_zero_i = 1'b0, rx_sf_fs_one_i = 1'b0;
  logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, cand_mask_i = 8'h00;
  logic [3:0]  rx_sig_i = 4'h0, tx_sig_i = 4'h0;
  logic [5:0]  tx_crc_i = 6'h00;
  logic [15:0] rx_dl_word_i = 16'h0000;
  logic [7:0]  rdata_o;
  logic [3:0]  rx_signaling_out_o, tx_sig_o;
  logic [5:0]  tx_crc_o;
  logic [15:0] yel_dl_word_o;
  logic [2:0]  sync_pos_o;
  logic [1:0]  fmt_o;
  logic        rx_frame_i, tx_frame_i, crc_feed_o, yel_sf_bit2_zero_o, yel_sf_fs_one_o;
  logic        rx_yellow_o, sync_ok_o, japan_variant_select_o, j, y, ey;
  int          mismatches = 0, checks = 0, cycles = 0, frames;
  tfoc_row_t   r;

  tfoc_top DUT (.mclk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_frame_i, .tx_frame_i,
    .rx_sig_i, .rx_sig_valid_i, .rx_signaling_out_o, .tx_sig_i, .tx_sig_valid_i, .tx_sig_o, .tx_crc_i,
    .tx_crc_valid_i, .tx_crc_o, .crc_bit_i, .extended_frame_alignment_bit_i, .crc_feed_o, .tx_yellow_req_i,
    .yel_dl_word_o, .yel_sf_bit2_zero_o, .yel_sf_fs_one_o, .rx_dl_word_i, .rx_sf_bit2_zero_i,
    .rx_sf_fs_one_i, .rx_yellow_o, .cand_mask_i, .window_end_i, .sync_ok_o, .sync_pos_o, .fmt_o,
    .japan_variant_select_o);

  tfoc_line_model #(.PERIOD(4)) LINE (.mclk_i, .reset_n_i, .en_i(line_en), .rx_frame_o(rx_frame_i),
    .tx_frame_o(tx_frame_i));

  // ---------------------------------------------------------------
  // clock, frame count, timeout
  // ---------------------------------------------------------------
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    frames <= !reset_n_i ? 0 : frames + int'(rx_frame_i);
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd

  task automatic sig(input logic [3:0] rx, input logic [3:0] tx);
    @(posedge mclk_i);
    rx_sig_i       <= rx;
    tx_sig_i       <= tx;
    rx_sig_valid_i <= 1'b1;
    tx_sig_valid_i <= 1'b1;
    @(posedge mclk_i);
    rx_sig_valid_i <= 1'b0;
    tx_sig_valid_i <= 1'b0;
    #1;
  endtask : sig

  // deferred update must wait for the frame pulse that closes the superframe
  task automatic sig_case(input logic [7:0] cfg, input int n);
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    wr(tfoc_pkg::ADDR_FRAMING_SELECT, cfg);
    sig(4'hC, 4'h3);
    line_en <= 1'b1;
    wait (frames == n);
    #1;
    chk(rx_signaling_out_o, 4'h0);
    chk(tx_sig_o, 4'h0);
    repeat (2) @(posedge mclk_i);
    #1;
    chk(rx_signaling_out_o, 4'hC);
    chk(tx_sig_o, 4'h3);
    line_en <= 1'b0;
    rd(tfoc_pkg::ADDR_RX_SIG_ARRAY, 8'h0C);
  endtask : sig_case

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(tfoc_pkg::ADDR_FRAMING_SELECT, tfoc_pkg::FRAMING_SELECT_RST);
    chk(japan_variant_select_o, 1'b0);
    for (int i = 0; i < 9; i++) begin
      r = ROWS[i];
      j = r.cfg[5];
      wr(tfoc_pkg::ADDR_FRAMING_SELECT, r.cfg);
      cand_mask_i <= r.cand;
      tx_crc_i <= 6'h2A ^ 6'(i);
      extended_frame_alignment_bit_i <= i[0];
      crc_bit_i <= i[1];
      y  = !(i[0] && i[1]);
      ey = (r.fmt == 2'h0) ? (j ? i[1] : !i[1]) : (j ? i[2] : i[1]);
      tx_yellow_req_i <= y;
      rx_dl_word_i <= i[1] ? 16'hFFFF : 16'hFF00;
      rx_sf_bit2_zero_i <= i[1];
      rx_sf_fs_one_i <= i[2];
      repeat (3) @(posedge mclk_i);
      #1;
      chk(sync_ok_o, r.ok);
      if (r.ok) chk(sync_pos_o, r.pos);
      chk(fmt_o, r.fmt);
      chk(japan_variant_select_o, j);
      chk(tx_crc_o, (6'h2A ^ 6'(i)) ^ {5'h00, r.cfg[6]});
      chk(crc_feed_o, (i[0] && !j) ? 1'b1 : i[1]);
      if (r.fmt == 2'h0) chk(yel_dl_word_o, y ? (j ? 16'hFFFF : 16'hFF00) : 16'h0000);
      if (r.fmt == 2'h1) chk({yel_sf_bit2_zero_o, yel_sf_fs_one_o}, {y & !j, y & j});
      if (r.fmt == 2'h0) chk(rx_yellow_o, j ? i[1] : !i[1]);
      if (r.fmt == 2'h1) chk(rx_yellow_o, j ? i[2] : i[1]);
      rd(tfoc_pkg::ADDR_FRAMING_SELECT, r.cfg);
      if (!r.fmt[1]) rd(tfoc_pkg::ADDR_STATUS, {5'h00, ey, r.ok, j});
    end
    // unmapped and read-only places
    wr(8'hFC, 8'hFF);
    wr(tfoc_pkg::ADDR_RX_SIG_ARRAY, 8'h0F);
    rd(8'hFC, 8'h00);
    rd(tfoc_pkg::ADDR_RX_SIG_ARRAY, 8'h00);
    wr(tfoc_pkg::ADDR_FRAMING_SELECT, 8'h00);
    sig(4'h9, 4'h6);
    chk(rx_signaling_out_o, 4'h9);
    chk(tx_sig_o, 4'h6);
    rd(tfoc_pkg::ADDR_RX_SIG_ARRAY, 8'h09);
    sig_case(8'h80, 24);
    sig_case(8'h85, 12);
    end_of_test();
  end
endmodule : tfoc_top_bench
